//--- tswdt_consts.svh
// Offsets, reset values and key constants of the two-stage watchdog
`ifndef TSWDT_CONSTS_SVH
`define TSWDT_CONSTS_SVH

`define TSWDT_OFS_RELOAD    12'h000
`define TSWDT_OFS_VALUE     12'h004
`define TSWDT_OFS_CONTROL   12'h008
`define TSWDT_OFS_IRQ_CLEAR 12'h00C
`define TSWDT_OFS_RAW_IRQ   12'h010
`define TSWDT_OFS_MASK_IRQ  12'h014
`define TSWDT_OFS_IRQ_MASK  12'h020
`define TSWDT_OFS_LOCK      12'hC00
`define TSWDT_OFS_CLK_GATE  12'h024

`define TSWDT_RST_RELOAD    32'hFFFFFFFF
`define TSWDT_RST_VALUE     32'hFFFFFFFF
`define TSWDT_UNLOCK_KEY    32'h1ACCE551

`define TSWDT_BIT_IRQ_EN    0
`define TSWDT_BIT_RES_EN    1

`endif

//--- tswdt_pkg.sv
// Types of the two-stage watchdog
package tswdt_pkg;
  typedef enum logic [1:0] {
    TSWDT_IDLE,
    TSWDT_FIRST,
    TSWDT_SECOND
  } tswdt_stage_type;
endpackage

//--- tswdt_top.sv
// Two-stage watchdog timer with classic Wishbone register slave
//
// Implementation choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "tswdt_consts.svh"

module tswdt_top
  import tswdt_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  // System side
  output logic             irq_o,
  output logic             sys_reset_o
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  logic [31:0]     reload_value_reg;
  logic [31:0]     count;
  logic            irq_enable;
  logic            reset_output_enable;
  logic            raw_irq_status;
  logic            irq_mask;
  logic            locked;
  logic            timeout_unit_clock_gate;
  logic            ack_q;
  tswdt_stage_type stage;

  logic            req;
  logic            wr;
  logic            rd;
  logic            mapped;
  logic            wr_ok;
  logic            full_word;
  logic            wr_reload;
  logic            wr_control;
  logic            wr_clear;
  logic            wr_lock;
  logic            rd_mask_irq;
  logic            masked_irq_status;
  logic            at_zero;
  logic            running;
  logic            irq_set;
  logic            enable_rise;
  logic [31:0]     next_count;
  logic [31:0]     rd_data;

  // ------------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------------
  // One wait state: ack follows a registered request, then drops
  // Err must also block, or an unmapped access answers twice
  assign req       = wb_cyc_i & wb_stb_i & ~ack_q & ~wb_err_o;
  assign wr        = req & wb_we_i;
  assign rd        = req & ~wb_we_i;
  assign full_word = (wb_sel_i == 4'hF);
  always_comb begin
    unique case (wb_adr_i)
      `TSWDT_OFS_RELOAD, `TSWDT_OFS_VALUE, `TSWDT_OFS_CONTROL,
      `TSWDT_OFS_IRQ_CLEAR, `TSWDT_OFS_RAW_IRQ, `TSWDT_OFS_MASK_IRQ,
      `TSWDT_OFS_IRQ_MASK, `TSWDT_OFS_LOCK, `TSWDT_OFS_CLK_GATE:
        mapped = 1'b1;
      default:
        mapped = 1'b0;
    endcase
  end

  // Lock and clock gate both block writes; lock and gate regs stay open
  assign wr_ok       = wr & full_word & ~locked
                       & timeout_unit_clock_gate;
  assign wr_reload   = wr_ok & (wb_adr_i == `TSWDT_OFS_RELOAD);
  assign wr_control  = wr_ok & (wb_adr_i == `TSWDT_OFS_CONTROL)
                       & ~irq_enable;
  assign wr_clear    = wr_ok & (wb_adr_i == `TSWDT_OFS_IRQ_CLEAR);
  assign wr_lock     = wr & full_word & (wb_adr_i == `TSWDT_OFS_LOCK);
  assign rd_mask_irq = rd & (wb_adr_i == `TSWDT_OFS_MASK_IRQ);
  assign enable_rise = wr_control & wb_dat_i[`TSWDT_BIT_IRQ_EN];

  // ------------------------------------------------------------------
  // Counter
  // ------------------------------------------------------------------
  assign running = irq_enable & timeout_unit_clock_gate;
  assign at_zero = running & (count == 32'h00000000);

  always_comb begin
    next_count = count;
    if (wr_reload) begin
      next_count = wb_dat_i;
    end else if (enable_rise || wr_clear) begin
      next_count = reload_value_reg;
    end else if (at_zero) begin
      next_count = reload_value_reg;
    end else if (running) begin
      next_count = count - 32'h00000001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count <= `TSWDT_RST_VALUE;
    end else begin
      count <= next_count;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reload_value_reg <= `TSWDT_RST_RELOAD;
    end else if (wr_reload) begin
      reload_value_reg <= wb_dat_i;
    end
  end

  // ------------------------------------------------------------------
  // Control, lock and clock gate
  // ------------------------------------------------------------------
  // Only a hardware reset reopens the control register once enabled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_enable          <= 1'b0;
      reset_output_enable <= 1'b0;
    end else if (wr_control) begin
      irq_enable          <= wb_dat_i[`TSWDT_BIT_IRQ_EN];
      reset_output_enable <= wb_dat_i[`TSWDT_BIT_RES_EN];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      locked <= 1'b0;
    end else if (wr_lock) begin
      locked <= (wb_dat_i != `TSWDT_UNLOCK_KEY);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timeout_unit_clock_gate <= 1'b0;
    end else if (wr & full_word & (wb_adr_i == `TSWDT_OFS_CLK_GATE)) begin
      timeout_unit_clock_gate <= wb_dat_i[0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask <= 1'b1;
    end else if (wr_ok & (wb_adr_i == `TSWDT_OFS_IRQ_MASK)) begin
      irq_mask <= wb_dat_i[0];
    end
  end

  // ------------------------------------------------------------------
  // Interrupt and reset stages
  // ------------------------------------------------------------------
  // A zero load counts as an immediate time-out
  assign irq_set = at_zero | (wr_reload & (wb_dat_i == 32'h00000000)
                              & irq_enable);

  // Set beats clear; masked-status read acts as the sticky-bit clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      raw_irq_status <= 1'b0;
    end else if (irq_set) begin
      raw_irq_status <= 1'b1;
    end else if (wr_clear || rd_mask_irq) begin
      raw_irq_status <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stage <= TSWDT_IDLE;
    end else begin
      unique case (stage)
        TSWDT_IDLE:   if (running) stage <= TSWDT_FIRST;
        TSWDT_FIRST:  if (at_zero && raw_irq_status
                          && reset_output_enable) stage <= TSWDT_SECOND;
        TSWDT_SECOND: stage <= TSWDT_SECOND;
      endcase
    end
  end

  assign sys_reset_o       = (stage == TSWDT_SECOND);
  assign masked_irq_status = raw_irq_status & irq_enable;
  assign irq_o             = masked_irq_status & irq_mask;

  // ------------------------------------------------------------------
  // Read data and acknowledge
  // ------------------------------------------------------------------
  always_comb begin
    rd_data = 32'h00000000;
    unique case (wb_adr_i)
      `TSWDT_OFS_RELOAD:   rd_data = reload_value_reg;
      `TSWDT_OFS_VALUE:    rd_data = count;
      `TSWDT_OFS_CONTROL:  rd_data = {30'h0, reset_output_enable,
                                      irq_enable};
      `TSWDT_OFS_RAW_IRQ:  rd_data = {31'h0, raw_irq_status};
      `TSWDT_OFS_MASK_IRQ: rd_data = {31'h0, masked_irq_status};
      `TSWDT_OFS_IRQ_MASK: rd_data = {31'h0, irq_mask};
      `TSWDT_OFS_LOCK:     rd_data = {31'h0, locked};
      `TSWDT_OFS_CLK_GATE: rd_data = {31'h0, timeout_unit_clock_gate};
      default:             rd_data = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q    <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      ack_q    <= req & mapped;
      wb_err_o <= req & ~mapped;
      wb_dat_o <= rd ? rd_data : 32'h00000000;
    end
  end

  assign wb_ack_o = ack_q;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  sequence s_zero_pending;
    at_zero && raw_irq_status && reset_output_enable
      && stage == TSWDT_FIRST;
  endsequence

  a_second_timeout: assert property (@(posedge clk_i) disable iff (rst_i)
    s_zero_pending |=> sys_reset_o)
    else $error("second time-out did not reset");
  a_count_down: assert property (@(posedge clk_i) disable iff (rst_i)
    running && !at_zero && !wr_ok |=> count == $past(count) - 32'h00000001)
    else $error("counter did not decrement");
  a_hold_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !irq_enable && !wr_ok |=> $stable(count) && !sys_reset_o)
    else $error("counter moved before enable");
  a_reload_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    at_zero && !wr_ok |=> count == reload_value_reg && raw_irq_status)
    else $error("no reload after time-out");
  a_load_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_reload |=> count == $past(wb_dat_i))
    else $error("load write not applied");
  a_load_keeps: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_reload && raw_irq_status && !rd_mask_irq |=> raw_irq_status)
    else $error("load write cleared interrupt");
  a_clear_reload: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_clear && !at_zero |=> !raw_irq_status && count == reload_value_reg)
    else $error("clear did not reload");
  a_ctrl_locked: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_enable |=> irq_enable && $stable(reset_output_enable))
    else $error("control changed after enable");
  a_key_unlock: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_lock |=> locked == ($past(wb_dat_i) != `TSWDT_UNLOCK_KEY))
    else $error("lock key mishandled");
  a_masked_and: assert property (@(posedge clk_i) disable iff (rst_i)
    masked_irq_status == (raw_irq_status && irq_enable))
    else $error("masked status wrong");

  sequence s_zero_load;
    wr_reload && wb_dat_i == 32'h00000000 && irq_enable;
  endsequence

  a_zero_load: assert property (@(posedge clk_i) disable iff (rst_i)
    s_zero_load |=> raw_irq_status)
    else $error("zero load gave no interrupt");
  a_reset_sticks: assert property (@(posedge clk_i) disable iff (rst_i)
    sys_reset_o |=> sys_reset_o)
    else $error("system reset dropped");
  a_irq_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    raw_irq_status && !wr_clear && !rd_mask_irq |=> raw_irq_status)
    else $error("interrupt lost without clear");
  a_enable_preload: assert property (@(posedge clk_i) disable iff (rst_i)
    enable_rise |=> count == reload_value_reg)
    else $error("enable did not preload counter");

endmodule

`default_nettype wire

//--- tswdt_sys_model.sv
// System-side interrupt and reset sink facing the watchdog
`timescale 1ns/10ps
`default_nettype none
module tswdt_sys_model (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Watchdog outputs
  input  wire logic       irq_i,
  input  wire logic       sys_reset_i,
  // Observations
  output logic      [7:0] irq_edges_o,
  output logic            reset_taken_o
);
  logic irq_d;
  // Edges counted, since the level alone hides a re-raised interrupt
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_d <= 1'b0;
      irq_edges_o <= 8'h00;
      reset_taken_o <= 1'b0;
    end else begin
      irq_d <= irq_i;
      if (irq_i && !irq_d) begin
        irq_edges_o <= irq_edges_o + 8'h01;
      end
      if (sys_reset_i) begin
        reset_taken_o <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

//--- two_stage_watchdog_timer_bench.sv
// Self-checking bench for the two-stage watchdog
`timescale 1ns/10ps
`default_nettype none
`include "tswdt_consts.svh"
module two_stage_watchdog_timer_bench;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [3:0]  sel = 4'hF;
  logic [31:0] dat = 32'h0, wb_dat_o, ld;
  logic        wb_ack_o, wb_err_o, irq_o, sys_reset_o, rst_seen;
  logic [7:0]  irq_edges;
  logic [32:0] exp_q[$];
  int          n_errors = 0, n_compared = 0, n;
  tswdt_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o), .irq_o(irq_o), .sys_reset_o(sys_reset_o));
  tswdt_sys_model sys_u (.clk_i(clk_i), .rst_i(rst_i), .irq_i(irq_o),
    .sys_reset_i(sys_reset_o), .irq_edges_o(irq_edges),
    .reset_taken_o(rst_seen));
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic wrap_up();
    if (n_errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic ok);
    n_compared++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("BAD %0t flag or timing mismatch", $time);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [32:0] e);
    int k;
    k = 0;
    exp_q.push_back(e);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
      k++;
    end while (!(wb_ack_o || wb_err_o) && k < 50);
    if (k >= 50) chk(1'b0);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 33'h0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, {1'b0, e});
  endtask
  // Waits a bounded time for interrupt (0) or system reset (1)
  // One more edge, so the sink's registered counts have settled
  task automatic wait_for(input bit rs);
    n = 0;
    while (((rs ? sys_reset_o : irq_o) !== 1'b1) && n < 400) begin
      @(posedge clk_i);
      n++;
    end
    @(posedge clk_i);
  endtask
  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask
  // ------------------------------------------------------------
  // Result monitor
  // ------------------------------------------------------------
  always @(posedge clk_i) begin
    if (wb_ack_o || wb_err_o) begin
      n_compared++;
      if (exp_q.size() == 0 || {wb_err_o, wb_dat_o} !== exp_q[0]) begin
        n_errors++;
        $display("BAD %0t bus answer %h", $time, {wb_err_o, wb_dat_o});
      end
      if (exp_q.size() > 0) void'(exp_q.pop_front());
    end
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    n_errors++;
    wrap_up();
  end
  initial begin
    void'($urandom(76));
    ld = 32'h40 + ($urandom % 32'h20);
    do_reset();
    rd(`TSWDT_OFS_RELOAD, `TSWDT_RST_RELOAD);
    rd(`TSWDT_OFS_CONTROL, 32'h0);
    bus(1'b0, 12'h100, 32'h0, {1'b1, 32'h0});
    wr(`TSWDT_OFS_CLK_GATE, 32'h1);
    repeat (20) @(posedge clk_i);
    rd(`TSWDT_OFS_VALUE, `TSWDT_RST_VALUE);
    wr(`TSWDT_OFS_RELOAD, ld);
    wr(`TSWDT_OFS_CONTROL, 32'h3);
    wr(`TSWDT_OFS_CONTROL, 32'h0);
    rd(`TSWDT_OFS_CONTROL, 32'h3);
    wait_for(1'b0);
    chk(n + 24 >= ld && n <= ld + 8);
    rd(`TSWDT_OFS_RAW_IRQ, 32'h1);
    wr(`TSWDT_OFS_RELOAD, ld);
    rd(`TSWDT_OFS_RAW_IRQ, 32'h1);
    wr(`TSWDT_OFS_IRQ_CLEAR, $urandom);
    rd(`TSWDT_OFS_RAW_IRQ, 32'h0);
    chk(irq_o === 1'b0 && sys_reset_o === 1'b0);
    wait_for(1'b0);
    chk(n + 24 >= ld && n <= ld + 8 && irq_edges === 8'h02);
    wait_for(1'b1);
    chk(n + 4 >= ld && n <= ld + 8 && rst_seen === 1'b1);
    rd(`TSWDT_OFS_MASK_IRQ, 32'h1);
    rd(`TSWDT_OFS_RAW_IRQ, 32'h0);
    do_reset();
    wr(`TSWDT_OFS_CLK_GATE, 32'h1);
    wr(`TSWDT_OFS_CONTROL, 32'h1);
    wr(`TSWDT_OFS_RELOAD, 32'h0);
    rd(`TSWDT_OFS_RAW_IRQ, 32'h1);
    repeat (20) @(posedge clk_i);
    chk(sys_reset_o === 1'b0 && irq_o === 1'b1);
    wr(`TSWDT_OFS_IRQ_MASK, 32'h0);
    chk(irq_o === 1'b0 && sys_reset_o === 1'b0);
    rd(`TSWDT_OFS_MASK_IRQ, 32'h1);
    // Low half cleared so the random value can never be the key
    wr(`TSWDT_OFS_LOCK, $urandom & 32'hFFFF0000);
    rd(`TSWDT_OFS_LOCK, 32'h1);
    wr(`TSWDT_OFS_RELOAD, ld);
    rd(`TSWDT_OFS_RELOAD, 32'h0);
    wr(`TSWDT_OFS_LOCK, `TSWDT_UNLOCK_KEY);
    rd(`TSWDT_OFS_LOCK, 32'h0);
    wr(`TSWDT_OFS_RELOAD, ld);
    rd(`TSWDT_OFS_RELOAD, ld);
    repeat (2) @(posedge clk_i);
    wrap_up();
  end
endmodule
`default_nettype wire
